// *** hw/bst_dual_tap.sv ***
// dual-channel boundary-scan tap: two controllers, chained a then b
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module bst_dual_tap
  import bst_pkg::*;
#(
  // identification word, arbitrary value
  parameter logic [31:0] ID_WORD = BST_ID_DEFAULT
) (
  // system clock domain
  input  wire logic                            i_clk,
  input  wire logic                            i_rst_b,
  // test port pins
  input  wire logic                            i_tck,
  input  wire logic                            i_tms,
  input  wire logic                            i_tms_drv,
  input  wire logic                            i_tdi,
  input  wire logic                            i_tdi_drv,
  output logic                                 o_tdo,
  output logic                                 o_tdo_oe,
  // boundary cells, per channel (observed pins asynchronous, parallel outputs in tck domain)
  input  wire logic [BST_NUM_CH-1:0][47:0]     i_pin_obs,
  output logic      [BST_NUM_CH-1:0][47:0]     o_bsr_par,
  // temperature readout, per channel (system clock domain)
  input  wire logic [BST_NUM_CH-1:0][7:0]      i_temp,
  // test modes toward the functional pins (system clock domain)
  output logic      [BST_NUM_CH-1:0]           o_mode_extest,
  output logic      [BST_NUM_CH-1:0]           o_mode_clamp,
  output logic      [BST_NUM_CH-1:0]           o_mode_highz
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  bst_clk_s                       clk_reg;     // system clock state
  bst_clk_s                       clk_next;    // its next value
  bst_tck_s                       tck_reg;     // tck-side handshake state
  bst_tck_s                       tck_next;    // its next value
  bst_rise_s [BST_NUM_CH-1:0]     rise_reg;    // shift stages
  bst_rise_s [BST_NUM_CH-1:0]     rise_next;   // their next values
  bst_fall_s [BST_NUM_CH-1:0]     fall_reg;    // parallel stages and tdo
  bst_fall_s [BST_NUM_CH-1:0]     fall_next;   // their next values
  bst_state_e [BST_NUM_CH-1:0]    tap_state;   // controller states
  logic [BST_NUM_CH-1:0]          ch_tdi;      // serial in per channel
  logic [BST_NUM_CH-1:0][47:0]    pin_sync;    // observed pins after sync
  logic [BST_NUM_CH-1:0][2:0]     mode_sync;   // modes in system domain
  logic [BST_NUM_CH-1:0][2:0]     mode_tck;    // modes in tck domain
  logic                           tck_rst_b;   // tck-domain reset
  logic                           tms_eff;     // tms after pull-up
  logic                           tdi_eff;     // tdi after pull-up
  logic                           ack_sync;    // handshake ack, tck side
  logic                           req_sync;    // handshake req, clock side

  ////////////////////////////////////////////////////////////////////////////
  // pin conditioning

  // an undriven pin floats to one through the pull-up
  assign tms_eff = i_tms | ~i_tms_drv;
  assign tdi_eff = i_tdi | ~i_tdi_drv;

  // channel a takes the pin, channel b takes a's launched output
  assign ch_tdi[0] = tdi_eff;
  assign ch_tdi[1] = fall_reg[0].tdo;

  // external pin shows channel b only
  assign o_tdo    = fall_reg[BST_NUM_CH-1].tdo;
  assign o_tdo_oe = fall_reg[BST_NUM_CH-1].tdo_oe;

  ////////////////////////////////////////////////////////////////////////////
  // system clock side: init level and temperature hold

  // hold only reloads when tck has asked again, so tck reads a still word
  always_comb begin
    clk_next        = clk_reg;
    clk_next.init_b = 1'b1;
    if (req_sync != clk_reg.ack) begin
      clk_next.hold = i_temp;
      clk_next.ack  = ~clk_reg.ack;
    end
  end

  // synchronous reset; init_b follows it one edge late
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      clk_reg <= '0;
    end else begin
      clk_reg <= clk_next;
    end
  end

  // request toggle into the system clock domain
  bst_sync #(.W(1)) u_req_sync (
    .i_clk    (i_clk),
    .i_aclr_b (1'b1),
    .i_srst_b (i_rst_b),
    .i_d      (tck_reg.req),
    .o_q      (req_sync)
  );

  // test modes into the system clock domain, each a quiet level
  bst_sync #(.W(BST_NUM_CH * BST_MODE_W)) u_mode_sync (
    .i_clk    (i_clk),
    .i_aclr_b (1'b1),
    .i_srst_b (i_rst_b),
    .i_d      (mode_tck),
    .o_q      (mode_sync)
  );

  // mode outputs
  always_comb begin
    for (int c = 0; c < BST_NUM_CH; c++) begin
      o_mode_extest[c] = mode_sync[c][BST_MODE_EXTEST];
      o_mode_clamp[c]  = mode_sync[c][BST_MODE_CLAMP];
      o_mode_highz[c]  = mode_sync[c][BST_MODE_HIGHZ];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tck domain: reset, pins, handshake

  // assert at once on init, release on tck so no half-reset edge occurs
  bst_sync #(.W(1)) u_rst_sync (
    .i_clk    (i_tck),
    .i_aclr_b (clk_reg.init_b),
    .i_srst_b (1'b1),
    .i_d      (1'b1),
    .o_q      (tck_rst_b)
  );

  // functional pins are asynchronous to tck
  bst_sync #(.W(BST_NUM_CH * BST_BSR_W)) u_pin_sync (
    .i_clk    (i_tck),
    .i_aclr_b (tck_rst_b),
    .i_srst_b (1'b1),
    .i_d      (i_pin_obs),
    .o_q      (pin_sync)
  );

  // acknowledge toggle into the tck domain
  bst_sync #(.W(1)) u_ack_sync (
    .i_clk    (i_tck),
    .i_aclr_b (tck_rst_b),
    .i_srst_b (1'b1),
    .i_d      (clk_reg.ack),
    .o_q      (ack_sync)
  );

  // take the held word once acknowledged, then ask for a fresh one;
  // the reading lags the sensor by a few clocks of both domains
  always_comb begin
    tck_next = tck_reg;
    if (ack_sync == tck_reg.req) begin
      tck_next.temp = clk_reg.hold;
      tck_next.req  = ~tck_reg.req;
    end
  end

  // handshake register
  always_ff @(posedge i_tck or negedge tck_rst_b) begin
    if (!tck_rst_b) begin
      tck_reg <= '0;
    end else begin
      tck_reg <= tck_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel controller and data path

  for (genvar c = 0; c < BST_NUM_CH; c++) begin : g_ch

    // shared tck and tms keep both controllers in step
    bst_tap_fsm u_fsm (
      .i_tck    (i_tck),
      .i_init_b (tck_rst_b),
      .i_tms    (tms_eff),
      .o_state  (tap_state[c])
    );

    // register selection by the active instruction
    logic sel_bsr; // sample, preload or extest
    logic sel_id;  // identification read
    logic sel_tmp; // temperature read
    assign sel_bsr = (fall_reg[c].ir_act == BST_OP_SAMPLE) ||
                     (fall_reg[c].ir_act == BST_OP_EXTEST);
    assign sel_id  = (fall_reg[c].ir_act == BST_OP_IDREAD);
    assign sel_tmp = (fall_reg[c].ir_act == BST_OP_TEMP);

    // capture and shift act on the rising edge leaving the state
    always_comb begin
      rise_next[c] = rise_reg[c];
      unique case (tap_state[c])
        ST_CAP_IR: begin
          rise_next[c].ir_sh = BST_IR_CAPTURE;
        end
        ST_SH_IR: begin
          rise_next[c].ir_sh = {ch_tdi[c], rise_reg[c].ir_sh[7:1]};
        end
        ST_CAP_DR: begin
          // pass cell is the default path, also for unknown codes
          if (sel_bsr) begin
            rise_next[c].bsr_sh = pin_sync[c];
          end else if (sel_id) begin
            rise_next[c].id_sh = ID_WORD;
          end else if (sel_tmp) begin
            rise_next[c].tmp_sh = tck_reg.temp[c];
          end else begin
            rise_next[c].pass_sh = BST_PASS_CAPT;
          end
        end
        ST_SH_DR: begin
          // tdi in at the msb, lsb goes out next
          if (sel_bsr) begin
            rise_next[c].bsr_sh = {ch_tdi[c], rise_reg[c].bsr_sh[47:1]};
          end else if (sel_id) begin
            rise_next[c].id_sh = {ch_tdi[c], rise_reg[c].id_sh[31:1]};
          end else if (sel_tmp) begin
            rise_next[c].tmp_sh = {ch_tdi[c], rise_reg[c].tmp_sh[7:1]};
          end else begin
            rise_next[c].pass_sh = ch_tdi[c];
          end
        end
        // select, exit, pause, update and idle leave data registers alone
        ST_TLR, ST_RTI, ST_SEL_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
        ST_UPD_DR, ST_SEL_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR,
        ST_UPD_IR: begin
          rise_next[c] = rise_reg[c];
        end
      endcase
    end

    // rising-edge sampling of every test input
    always_ff @(posedge i_tck or negedge tck_rst_b) begin
      if (!tck_rst_b) begin
        rise_reg[c] <= '0;
      end else begin
        rise_reg[c] <= rise_next[c];
      end
    end

    // falling stage: updates, tdo launch and its enable
    always_comb begin
      fall_next[c] = fall_reg[c];
      unique case (tap_state[c])
        ST_TLR: begin
          fall_next[c].ir_act = BST_IR_RESET;
        end
        ST_UPD_IR: begin
          fall_next[c].ir_act = rise_reg[c].ir_sh;
        end
        ST_UPD_DR: begin
          // only boundary cells own a parallel output stage
          if (sel_bsr) begin
            fall_next[c].bsr_upd = rise_reg[c].bsr_sh;
          end
        end
        default: begin
          fall_next[c].ir_act = fall_reg[c].ir_act;
        end
      endcase
      // test modes follow the applied instruction
      fall_next[c].mode[BST_MODE_EXTEST] = (fall_next[c].ir_act == BST_OP_EXTEST);
      fall_next[c].mode[BST_MODE_CLAMP]  = (fall_next[c].ir_act == BST_OP_CLAMP);
      fall_next[c].mode[BST_MODE_HIGHZ]  = (fall_next[c].ir_act == BST_OP_HIGHZ);
      // bit 0 of whichever register sits in the path
      if (tap_state[c] == ST_SH_IR) begin
        fall_next[c].tdo = rise_reg[c].ir_sh[0];
      end else if (sel_bsr) begin
        fall_next[c].tdo = rise_reg[c].bsr_sh[0];
      end else if (sel_id) begin
        fall_next[c].tdo = rise_reg[c].id_sh[0];
      end else if (sel_tmp) begin
        fall_next[c].tdo = rise_reg[c].tmp_sh[0];
      end else begin
        fall_next[c].tdo = rise_reg[c].pass_sh;
      end
      // driver live only while shifting
      fall_next[c].tdo_oe = (tap_state[c] == ST_SH_IR) ||
                            (tap_state[c] == ST_SH_DR);
    end

    // falling-edge launch; init puts the id-read code back at once
    always_ff @(negedge i_tck or negedge tck_rst_b) begin
      if (!tck_rst_b) begin
        fall_reg[c].ir_act  <= BST_IR_RESET;
        fall_reg[c].bsr_upd <= '0;
        fall_reg[c].mode    <= '0;
        fall_reg[c].tdo     <= 1'b0;
        fall_reg[c].tdo_oe  <= 1'b0;
      end else begin
        fall_reg[c] <= fall_next[c];
      end
    end

    // outputs and crossings of this channel
    assign o_bsr_par[c] = fall_reg[c].bsr_upd;
    assign mode_tck[c]  = fall_reg[c].mode;

  end

endmodule

// *** hw/bst_pkg.sv ***
// package: constants, states and carrier structs for the dual boundary-scan tap
package bst_pkg;

  // channel count and register lengths
  localparam int unsigned BST_NUM_CH   = 2;
  localparam int unsigned BST_IR_W     = 8;
  localparam int unsigned BST_ID_W     = 32;
  localparam int unsigned BST_TMP_W    = 8;
  localparam int unsigned BST_BSR_W    = 48;
  localparam int unsigned BST_MODE_W   = 3;
  // tms-high edges that always reach test-logic-reset
  localparam int unsigned BST_TLR_EDGES = 5;

  // instruction opcodes
  localparam logic [7:0] BST_OP_PASS     = 8'h00;
  localparam logic [7:0] BST_OP_SAMPLE   = 8'h01;
  localparam logic [7:0] BST_OP_IDREAD   = 8'h02;
  localparam logic [7:0] BST_OP_CLAMP    = 8'h04;
  localparam logic [7:0] BST_OP_HIGHZ    = 8'h08;
  localparam logic [7:0] BST_OP_EXTEST   = 8'h10;
  localparam logic [7:0] BST_OP_TEMP     = 8'h20;

  // reset and capture values
  localparam logic [7:0] BST_IR_RESET    = BST_OP_IDREAD;
  localparam logic [7:0] BST_IR_CAPTURE  = 8'h01;
  localparam logic       BST_PASS_CAPT   = 1'b0;
  // identification word: arbitrary value, bit 0 kept at one
  localparam logic [31:0] BST_ID_DEFAULT = 32'h0000_0001;

  // mode bit positions passed to the functional side
  localparam int unsigned BST_MODE_EXTEST = 0;
  localparam int unsigned BST_MODE_CLAMP  = 1;
  localparam int unsigned BST_MODE_HIGHZ  = 2;

  // tap controller states
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bst_state_e;

  // per-channel shift stages, advanced on rising tck
  typedef struct packed {
    logic [7:0]  ir_sh;
    logic        pass_sh;
    logic [31:0] id_sh;
    logic [7:0]  tmp_sh;
    logic [47:0] bsr_sh;
  } bst_rise_s;

  // per-channel parallel stages and tdo, advanced on falling tck
  typedef struct packed {
    logic [7:0]  ir_act;
    logic [47:0] bsr_upd;
    logic [2:0]  mode;
    logic        tdo;
    logic        tdo_oe;
  } bst_fall_s;

  // tck-side half of the temperature handshake
  typedef struct packed {
    logic                          req;
    logic [BST_NUM_CH-1:0][7:0]    temp;
  } bst_tck_s;

  // system-clock side: init level and temperature hold
  typedef struct packed {
    logic                          init_b;
    logic                          ack;
    logic [BST_NUM_CH-1:0][7:0]    hold;
  } bst_clk_s;

endpackage

// *** hw/bst_sync.sv ***
// two-flop synchroniser with asynchronous and synchronous clear
`timescale 1ns/1ns
module bst_sync
  import bst_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // clock and clears
  input  wire logic         i_clk,
  input  wire logic         i_aclr_b,
  input  wire logic         i_srst_b,
  // data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  // both stages held in one packed word
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bst_sync_s;

  bst_sync_s sync_reg;  // present stages
  bst_sync_s sync_next; // next stages

  // the first stage feeds only the second
  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = i_srst_b ? i_d : '0;
    sync_next.s2 = i_srst_b ? sync_reg.s1 : '0;
  end

  // clear is asynchronous so a reset synchroniser can be built from this
  always_ff @(posedge i_clk or negedge i_aclr_b) begin
    if (!i_aclr_b) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign o_q = sync_reg.s2;

endmodule

// *** hw/bst_tap_fsm.sv ***
// sixteen-state tap controller, one instance per channel
`timescale 1ns/1ns
module bst_tap_fsm
  import bst_pkg::*;
(
  // test clock and asynchronous init
  input  wire logic i_tck,
  input  wire logic i_init_b,
  // mode select, already pulled up
  input  wire logic i_tms,
  // present state
  output bst_state_e o_state
);

  typedef struct packed {
    bst_state_e st;
  } bst_fsm_s;

  bst_fsm_s fsm_reg;  // present state
  bst_fsm_s fsm_next; // next state

  // next state from tms seen at the rising edge
  always_comb begin
    fsm_next = fsm_reg;
    unique case (fsm_reg.st)
      ST_TLR:    fsm_next.st = i_tms ? ST_TLR    : ST_RTI;
      ST_RTI:    fsm_next.st = i_tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: fsm_next.st = i_tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: fsm_next.st = i_tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  fsm_next.st = i_tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: fsm_next.st = i_tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: fsm_next.st = i_tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: fsm_next.st = i_tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: fsm_next.st = i_tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: fsm_next.st = i_tms ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: fsm_next.st = i_tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  fsm_next.st = i_tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: fsm_next.st = i_tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: fsm_next.st = i_tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: fsm_next.st = i_tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: fsm_next.st = i_tms ? ST_SEL_DR : ST_RTI;
    endcase
  end

  // init forces test-logic-reset without waiting for tck
  always_ff @(posedge i_tck or negedge i_init_b) begin
    if (!i_init_b) begin
      fsm_reg.st <= ST_TLR;
    end else begin
      fsm_reg <= fsm_next;
    end
  end

  assign o_state = fsm_reg.st;

endmodule

// *** tb/bst_dual_tap_props.sv ***
// checker: mirrored tap state and concurrent properties on the dual tap pins
`timescale 1ns/1ns
module bst_dual_tap_props
  import bst_pkg::*;
(
  // clocks and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_b,
  input  wire logic                        i_tck,
  // test port
  input  wire logic                        i_tms,
  input  wire logic                        i_tms_drv,
  input  wire logic                        o_tdo,
  input  wire logic                        o_tdo_oe,
  // parallel and mode outputs
  input  wire logic [BST_NUM_CH-1:0][47:0] o_bsr_par,
  input  wire logic [BST_NUM_CH-1:0]       o_mode_extest,
  input  wire logic [BST_NUM_CH-1:0]       o_mode_clamp,
  input  wire logic [BST_NUM_CH-1:0]       o_mode_highz
);
  logic       tms_e;  // tms as the pull-up makes it
  logic       sh_q;   // mirror sits in a shift state
  logic [1:0] warm_q; // design holds tlr for two edges after init
  bst_state_e st_q;   // mirrored controller state

  assign tms_e = i_tms_drv ? i_tms : 1'b1;
  assign sh_q  = (st_q == ST_SH_DR) || (st_q == ST_SH_IR);

  //////////////////////////////////////////////////////////////////////////////
  // mirror of the sixteen-state graph, cleared with reset
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q   <= ST_TLR;
      warm_q <= 2'h0;
    end else begin
      warm_q <= (warm_q == 2'h3) ? warm_q : warm_q + 2'h1;
      case (st_q)
        ST_TLR:                       st_q <= tms_e ? ST_TLR : ST_RTI;
        ST_RTI, ST_UPD_DR, ST_UPD_IR: st_q <= tms_e ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR:                    st_q <= tms_e ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR, ST_SH_DR:          st_q <= tms_e ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR, ST_EX2_DR:         st_q <= tms_e ? ST_UPD_DR : (st_q == ST_EX1_DR ?
                                              ST_PAU_DR : ST_SH_DR);
        ST_PAU_DR:                    st_q <= tms_e ? ST_EX2_DR : ST_PAU_DR;
        ST_SEL_IR:                    st_q <= tms_e ? ST_TLR : ST_CAP_IR;
        ST_CAP_IR, ST_SH_IR:          st_q <= tms_e ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR, ST_EX2_IR:         st_q <= tms_e ? ST_UPD_IR : (st_q == ST_EX1_IR ?
                                              ST_PAU_IR : ST_SH_IR);
        default:                      st_q <= tms_e ? ST_EX2_IR : ST_PAU_IR;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // scan entries from idle
  sequence s_ir_entry;
    (st_q == ST_RTI && tms_e) ##1 tms_e ##1 !tms_e ##1 !tms_e;
  endsequence
  sequence s_dr_entry;
    (st_q == ST_RTI && tms_e) ##1 !tms_e ##1 !tms_e;
  endsequence

  AST_OE_SHIFT:
  assert property (@(posedge i_tck) disable iff (warm_q != 2'h3) o_tdo_oe == sh_q)
    else $error("tdo enable disagrees with shift state");
  AST_TLR_FIVE:
  assert property (@(posedge i_tck) disable iff (warm_q != 2'h3) tms_e [*5] |=> !o_tdo_oe)
    else $error("tdo enabled after five tms-high edges");
  AST_RTI_HOLD:
  assert property (@(posedge i_tck) disable iff (warm_q != 2'h3)
    (st_q == ST_RTI && !tms_e) [*3] |=> !o_tdo_oe) else $error("idle left with tms low");
  AST_IR_ENTRY:
  assert property (@(posedge i_tck) disable iff (warm_q != 2'h3)
    s_ir_entry |=> o_tdo_oe && o_tdo) else $error("ir scan entry wrong");
  AST_DR_ENTRY:
  assert property (@(posedge i_tck) disable iff (warm_q != 2'h3)
    s_dr_entry |=> o_tdo_oe) else $error("dr shift not entered");
  AST_IR_PRESET:
  assert property (@(posedge i_tck) disable iff (warm_q != 2'h3)
    $past(st_q) == ST_CAP_IR && sh_q |-> o_tdo) else $error("ir preset bit 0 not one");
  AST_BSR_HOLD:
  assert property (@(posedge i_tck) disable iff (warm_q != 2'h3)
    st_q != ST_UPD_DR |-> $stable(o_bsr_par)) else $error("boundary stage moved");
  AST_MODE_RESET:
  assert property (@(posedge i_clk) disable iff (!i_rst_b) $rose(i_rst_b) |->
    (o_mode_extest == 2'h0 && o_mode_clamp == 2'h0 && o_mode_highz == 2'h0) [*3])
    else $error("test mode active after reset");
endmodule

// *** tb/bst_host_model.sv ***
// host test controller model: walks the tap graph, drives tms and tdi, samples tdo
`timescale 1ns/1ns
module bst_host_model
  import bst_pkg::*;
(
  // toward the device
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tms_drv,
  output logic      o_tdi,
  output logic      o_tdi_drv,
  // from the device
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe
);
  logic float_tms; // leave tms undriven, pin shows the inverse
  logic float_tdi; // leave tdi undriven, pin shows the inverse

  initial begin
    o_tck     = 1'b0;
    o_tms     = 1'b1;
    o_tms_drv = 1'b0;
    o_tdi     = 1'b0;
    o_tdi_drv = 1'b0;
    float_tms = 1'b0;
    float_tdi = 1'b0;
  end

  // one 30 ns tck period: change after falling, sample tdo at rising
  task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
    o_tms_drv = !float_tms;
    o_tms     = float_tms ? ~tms_v : tms_v;
    o_tdi_drv = !float_tdi;
    o_tdi     = float_tdi ? ~tdi_v : tdi_v;
    #15 o_tck = 1'b1;
    tdo_v     = i_tdo_oe ? i_tdo : 1'bx;
    #15 o_tck = 1'b0;
  endtask

  // between frames tck stands low and released lines hold no old value
  task automatic idle_lines();
    o_tms_drv = 1'b0;
    o_tms     = ~o_tms;
    o_tdi_drv = 1'b0;
    o_tdi     = ~o_tdi;
  endtask

  // five tms-high edges, then four low edges in idle
  task automatic tlr();
    logic t;
    repeat (5) step(1'b1, 1'b1, t);
    repeat (4) step(1'b0, 1'b1, t);
    idle_lines();
  endtask

  // scan from idle back to idle, with an optional pause after bit pz
  task automatic scan(input logic ir, input int n, input int pz,
                      input logic [127:0] din, output logic [127:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b1, t);
    if (ir) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    step(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == pz, din[i], t);
      dout[i] = t;
      if (i == pz && i != n - 1) begin
        step(1'b0, 1'b1, t);
        step(1'b0, 1'b1, t);
        step(1'b1, 1'b1, t);
        step(1'b0, 1'b1, t);
      end
    end
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    idle_lines();
  endtask
endmodule

// *** tb/testbench.sv ***
// testbench: dual tap driven by the host model with random instructions
`timescale 1ns/1ns
module testbench
  import bst_pkg::*;
;
  localparam logic [7:0] OPS [8] = '{BST_OP_PASS, BST_OP_SAMPLE, BST_OP_IDREAD,
    BST_OP_CLAMP, BST_OP_HIGHZ, BST_OP_EXTEST, BST_OP_TEMP, 8'h5a};
  logic                  clk, rst_b, tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, tb_bit;
  logic [1:0][47:0]      pin_obs, bsr_par;
  logic [1:0][7:0]       temp;
  logic [1:0]            m_ext, m_clp, m_hiz;
  logic [127:0]          dout;
  logic [7:0]            opc [2];
  logic [47:0]           exp_bsr [2];
  int                    err_count, num_checks;

  bst_host_model h (.o_tck(tck), .o_tms(tms), .o_tms_drv(tms_drv), .o_tdi(tdi),
    .o_tdi_drv(tdi_drv), .i_tdo(tdo), .i_tdo_oe(tdo_oe));
  bst_dual_tap uut (.i_clk(clk), .i_rst_b(rst_b), .i_tck(tck), .i_tms(tms),
    .i_tms_drv(tms_drv), .i_tdi(tdi), .i_tdi_drv(tdi_drv), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .i_pin_obs(pin_obs), .o_bsr_par(bsr_par), .i_temp(temp), .o_mode_extest(m_ext),
    .o_mode_clamp(m_clp), .o_mode_highz(m_hiz));

  //////////////////////////////////////////////////////////////////////////////
  // expected register length and capture value per instruction
  function automatic int dr_len(logic [7:0] op);
    case (op)
      BST_OP_SAMPLE, BST_OP_EXTEST: return 48;
      BST_OP_IDREAD:                return 32;
      BST_OP_TEMP:                  return 8;
      default:                      return 1;
    endcase
  endfunction
  function automatic logic [127:0] dr_cap(logic [7:0] op, int ch);
    case (op)
      BST_OP_SAMPLE, BST_OP_EXTEST: return 128'(pin_obs[ch]);
      BST_OP_IDREAD:                return 128'(BST_ID_DEFAULT);
      BST_OP_TEMP:                  return 128'(temp[ch]);
      default:                      return 128'h0;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [127:0] got, input logic [127:0] want);
    num_checks++;
    if (got !== want) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, want, got);
    end
  endtask

  task automatic results();
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // modes settle a few system clocks after update-ir
  task automatic chk_modes();
    repeat (8) @(negedge clk);
    for (int c = 0; c < 2; c++) begin
      chk("extest mode", m_ext[c], opc[c] == BST_OP_EXTEST);
      chk("clamp mode", m_clp[c], opc[c] == BST_OP_CLAMP);
      chk("highz mode", m_hiz[c], opc[c] == BST_OP_HIGHZ);
    end
  endtask

  // opcode a lands in the upper byte, nearest tdi
  task automatic load_ir();
    h.scan(1'b1, 16, -1, 128'({opc[0], opc[1]}), dout);
    chk("ir capture", dout, 128'h0101);
    chk_modes();
  endtask

  // chain b then a then eight pass-through bits, lsb first
  task automatic dr_run(input int pz);
    int           la, lb;
    logic [127:0] d, e;
    la = dr_len(opc[0]);
    lb = dr_len(opc[1]);
    d  = {$urandom, $urandom, $urandom, $urandom};
    e  = ((d & 128'hff) << (la + lb)) | (dr_cap(opc[0], 0) << lb) | dr_cap(opc[1], 1);
    h.scan(1'b0, la + lb + 8, pz, d, dout);
    chk("dr chain", dout, e);
    for (int c = 0; c < 2; c++)
      if (opc[c] == BST_OP_SAMPLE || opc[c] == BST_OP_EXTEST)
        exp_bsr[c] = 48'(d >> (c == 1 ? 8 : lb + 8));
    chk("bsr a", bsr_par[0], exp_bsr[0]);
    chk("bsr b", bsr_par[1], exp_bsr[1]);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  initial begin
    #900000;
    err_count++;
    results();
  end

  initial begin
    #1 rst_b   = 1'b0;
    pin_obs    = '0;
    temp       = '0;
    err_count  = 0;
    num_checks = 0;
    exp_bsr[0] = '0;
    exp_bsr[1] = '0;
    void'($urandom(63));
    repeat (2) @(negedge clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge clk);
    h.tlr();
    opc[0] = BST_OP_IDREAD;
    opc[1] = BST_OP_IDREAD;
    dr_run(-1);
    // every opcode on both channels, then random ones, some scans paused
    for (int k = 0; k < 16; k++) begin
      @(negedge clk);
      pin_obs <= {$urandom, $urandom, $urandom};
      temp    <= 16'($urandom);
      opc[0] = (k < 8) ? OPS[k] : OPS[$urandom_range(7)];
      opc[1] = (k < 8) ? OPS[(k + 3) % 8] : OPS[$urandom_range(7)];
      load_ir();
      dr_run((k % 3 == 0) ? int'($urandom_range(20)) : -1);
    end
    // undriven tdi reads as ones: unknown opcode, pass cells
    h.float_tdi = 1'b1;
    h.scan(1'b1, 16, -1, '1, dout);
    h.float_tdi = 1'b0;
    chk("ir float", dout, 128'h0101);
    opc[0] = 8'hff;
    opc[1] = 8'hff;
    dr_run(-1);
    opc[0] = BST_OP_EXTEST;
    opc[1] = BST_OP_EXTEST;
    load_ir();
    // undriven tms reaches test-logic-reset, instruction back to id read
    h.float_tms = 1'b1;
    repeat (5) h.step(1'b1, 1'b1, tb_bit);
    h.float_tms = 1'b0;
    h.step(1'b0, 1'b1, tb_bit);
    h.idle_lines();
    opc[0] = BST_OP_IDREAD;
    opc[1] = BST_OP_IDREAD;
    chk_modes();
    dr_run(-1);
    // reset in mid-run with extest active
    opc[0] = BST_OP_EXTEST;
    opc[1] = BST_OP_EXTEST;
    load_ir();
    @(negedge clk);
    rst_b <= 1'b0;
    repeat (3) @(negedge clk);
    chk("bsr in reset", bsr_par, 96'h0);
    chk("extest in reset", m_ext, 2'h0);
    rst_b <= 1'b1;
    repeat (4) @(negedge clk);
    h.tlr();
    opc[0] = BST_OP_IDREAD;
    opc[1] = BST_OP_IDREAD;
    exp_bsr[0] = '0;
    exp_bsr[1] = '0;
    dr_run(-1);
    results();
  end
endmodule

bind bst_dual_tap bst_dual_tap_props u_props (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_tck(i_tck), .i_tms(i_tms), .i_tms_drv(i_tms_drv), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
  .o_bsr_par(o_bsr_par), .o_mode_extest(o_mode_extest), .o_mode_clamp(o_mode_clamp),
  .o_mode_highz(o_mode_highz));
